// file: mcu_master.sv
// Purpose: microcontroller model that drives the watchdog registers over APB
// Assumes: every task is entered just after a rising clock edge
// Notes: one idle cycle follows each transfer so status has settled before the next read
module mcu_master
  import qa_watchdog_pkg::*;
(
  input wire logic clk_in, // bus clock
  input wire logic pready_in, // slave ready
  input wire logic pslverr_in, // slave error
  input wire logic [31:0] prdata_in, // read data
  output logic psel_out, // select
  output logic penable_out, // enable
  output logic pwrite_out, // direction
  output logic [7:0] paddr_out, // byte address
  output logic [31:0] pwdata_out // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    // no limit of its own: the bench's cycle ceiling ends a hung wait
    while (pready_in !== 1'b1) begin
      @(posedge clk_in);
    end
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released data lines must not keep looking valid
    pwdata_out <= ~d;
    @(posedge clk_in);
  endtask
  // n writes, the last one synchronised when sync is set
  task automatic answer(input logic [31:0] b, input logic sync, input int n);
    logic [31:0] r;
    logic e;
    for (int k = 0; k < n; k++) begin
      xfer(1'b1, (k == n - 1 && sync) ? ADDR_ANSWER_SYNC : ADDR_ANSWER_PLAIN,
           {24'h0, b[31-8*k -: 8]}, r, e);
    end
  endtask
endmodule

// file: qa_response_table.sv
// Purpose: expected answer byte for a question and a response position
// Assumes: position 0 is the first byte sent, 3 the last
// Notes: purely combinational constant lookup
module qa_response_table
  import qa_watchdog_pkg::*;
(
  input wire logic [3:0] question_in, // current question
  input wire logic [1:0] position_in, // response position
  output logic [7:0] expected_out // expected byte
);
  // each row: first, second, third, last byte
  localparam logic [31:0] ROWS [16] = '{
    32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
    32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
    32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474,
    32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};

  logic [31:0] row;

  always_comb begin
    row = ROWS[question_in];
    case (position_in)
      2'h0: expected_out = row[31:24];
      2'h1: expected_out = row[23:16];
      2'h2: expected_out = row[15:8];
      default: expected_out = row[7:0];
    endcase
  end
endmodule

// file: qa_watchdog.sv
// Purpose: question/answer functional watchdog with APB registers
// Assumes: APB inputs synchronous to ref_clk_in; one slave wait state
// Notes: the list below summarises the rules that the logic carries out
// Notes on behaviour
// - correct answer, last byte unsynced: valid, error minus one, new question
// - heartbeat expiry: invalid triggering, error plus two, heartbeat reset
// - after expiry question kept, heartbeat restarts from zero
// - wrong answer with synced last byte: heartbeat cleared, error plus two
// - after wrong answer the same question stays pending
// - each byte checked against expected byte of its position
// - answer evaluated only after four writes; heartbeat runs meanwhile
// - synced write that is not fourth does not reset heartbeat
// - a new question from a synced last byte restarts heartbeat from zero
// - question is four bits, answer four bytes compared bytewise
// - first three bytes plain, last synced; a synced last byte resets heartbeat whether correct or wrong
// - expected bytes from fixed sixteen-row table indexed by question
// - error over limit: move-to-init, heartbeat reset, error cleared
module qa_watchdog
  import qa_watchdog_pkg::*;
#(
  parameter int LONG_CYCLES = CYCLE_LONG_CLKS,
  parameter int SHORT_CYCLES = CYCLE_SHORT_CLKS
) (
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic rst_in, // async reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  output logic irq_out, // level interrupt
  output logic move_to_init_out // one-cycle move-to-init event
);
  wd_state_t q, d;
  logic [7:0] exp_byte;
  logic acc, wr_acc, resp_wr, is_sync, mismatch, eval, expire, bad_all;
  logic ev_valid, ev_invalid, init_evt;
  logic [DIV_W-1:0] div_lim;
  logic [4:0] err_sum;
  logic [31:0] rd;
  logic [3:0] ev_set;

  qa_response_table u_table (
    .question_in(q.quest),
    .position_in(q.pos),
    .expected_out(exp_byte)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_HB_PERIOD) || (a == ADDR_ERR_LIMIT) ||
             (a == ADDR_STATUS) || (a == ADDR_ANSWER_PLAIN) || (a == ADDR_ANSWER_SYNC) ||
             (a == ADDR_EVENT) || (a == ADDR_EVENT_MASK);
  endfunction

  assign acc = psel_in && penable_in && q.pready;
  assign wr_acc = acc && pwrite_in;
  assign is_sync = (paddr_in == ADDR_ANSWER_SYNC);
  assign resp_wr = wr_acc && q.en && ((paddr_in == ADDR_ANSWER_PLAIN) || is_sync);
  assign mismatch = (pwdata_in[7:0] != exp_byte);
  assign eval = resp_wr && (q.pos == POS_LAST);
  assign bad_all = q.bad || mismatch;
  // a finishing write wins over a same-cycle expiry; the expiry fires next tick unless the write cleared the heartbeat
  assign expire = q.en && q.tick && (q.hb >= q.hb_per) && !eval;
  assign ev_valid = eval && !bad_all;
  assign ev_invalid = (eval && bad_all) || expire;
  assign err_sum = {1'b0, q.err} + ERR_INC;
  assign init_evt = ev_invalid && (err_sum > {1'b0, q.limit});
  assign div_lim = q.cyc_short ? DIV_W'(SHORT_CYCLES - 1) : DIV_W'(LONG_CYCLES - 1);

  always_comb begin
    rd = 32'h0;
    case (paddr_in)
      ADDR_CTRL: begin
        rd[CTRL_EN_BIT] = q.en;
        rd[CTRL_SHORT_BIT] = q.cyc_short;
      end
      ADDR_HB_PERIOD: rd[7:0] = q.hb_per;
      ADDR_ERR_LIMIT: rd[3:0] = q.limit;
      ADDR_STATUS: begin
        rd[ST_QUEST_LSB +: 4] = q.quest;
        rd[ST_POS_LSB +: 2] = q.pos;
        rd[ST_ERR_LSB +: 4] = q.err;
        rd[ST_OUTCOME_BIT] = q.outcome;
      end
      ADDR_EVENT: rd[3:0] = q.ev;
      ADDR_EVENT_MASK: rd[3:0] = q.mask;
      default: rd = 32'h0;
    endcase
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.init_pulse = 1'b0;
    ev_set = 4'h0;
    // apb: ready one cycle into the access phase
    d.pready = psel_in && penable_in && !q.pready;
    d.pslverr = 1'b0;
    if (psel_in && penable_in && !q.pready) begin
      d.prdata = pwrite_in ? 32'h0 : rd;
      d.pslverr = !mapped(paddr_in);
    end
    if (wr_acc) begin
      case (paddr_in)
        ADDR_CTRL: begin
          d.en = pwdata_in[CTRL_EN_BIT];
          d.cyc_short = pwdata_in[CTRL_SHORT_BIT];
        end
        ADDR_HB_PERIOD: d.hb_per = pwdata_in[7:0];
        ADDR_ERR_LIMIT: d.limit = pwdata_in[3:0];
        ADDR_EVENT_MASK: d.mask = pwdata_in[3:0];
        default: d.ph = q.ph;
      endcase
    end
    // watchdog cycle divider and heartbeat counter
    if (q.en) begin
      if (q.div >= div_lim) begin
        d.div = '0;
        d.tick = 1'b1;
      end else begin
        d.div = q.div + DIV_W'(1);
      end
      // saturate: a wrap to zero would look like a heartbeat restart
      if (q.tick && (q.hb != 8'hff)) begin
        d.hb = q.hb + 8'h01;
      end
    end
    // answer collection
    if (resp_wr) begin
      if (eval) begin
        d.pos = 2'h0;
        d.bad = 1'b0;
        d.outcome = !bad_all;
        if (!bad_all) begin
          d.quest = q.quest + 4'h1;
          if (is_sync) begin
            d.hb = 8'h00;
          end
        end else if (is_sync) begin
          d.hb = 8'h00;
        end
      end else begin
        d.pos = q.pos + 2'h1;
        d.bad = bad_all;
      end
    end
    if (expire) begin
      d.hb = 8'h00;
      d.pos = 2'h0;
      d.bad = 1'b0;
      d.outcome = 1'b0;
    end
    // error counter
    if (ev_valid) begin
      if (q.err != 4'h0) begin
        d.err = q.err - ERR_DEC;
      end
    end else if (ev_invalid) begin
      if (init_evt) begin
        d.err = 4'h0;
        d.hb = 8'h00;
        d.init_pulse = 1'b1;
      end else begin
        d.err = err_sum[3:0];
      end
    end
    ev_set[EV_VALID] = ev_valid;
    ev_set[EV_INVALID] = ev_invalid;
    ev_set[EV_EXPIRE] = expire;
    ev_set[EV_INIT] = init_evt;
    // write-one-to-clear; a new event wins over the clear
    if (wr_acc && (paddr_in == ADDR_EVENT)) begin
      d.ev = (q.ev & ~pwdata_in[3:0]) | ev_set;
    end else begin
      d.ev = q.ev | ev_set;
    end
    if (!d.en) begin
      d.ph = PH_OFF;
      d.div = '0;
      d.hb = 8'h00;
      d.pos = 2'h0;
      d.bad = 1'b0;
      d.err = 4'h0;
    end else begin
      d.ph = PH_RUN;
    end
    d.irq = |(d.ev & d.mask);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{ph: PH_OFF, div: '0, tick: 1'b0, hb: 8'h00, quest: 4'h0, pos: 2'h0,
             bad: 1'b0, err: 4'h0, outcome: 1'b0, en: 1'b0, cyc_short: 1'b0,
             hb_per: HB_PERIOD_RST, limit: ERR_LIMIT_RST, ev: 4'h0, mask: 4'h0,
             pready: 1'b0, pslverr: 1'b0, prdata: 32'h0, irq: 1'b0,
             init_pulse: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign irq_out = q.irq;
  assign move_to_init_out = q.init_pulse;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_valid_dec;
    ev_valid && (q.err != 4'h0) && d.en |=> q.err == $past(q.err) - 4'h1;
  endproperty
  a_valid_dec: assert property (p_valid_dec) else $error("valid answer did not decrement");

  property p_unsync_keeps_hb;
    ev_valid && !is_sync && d.en |=> (q.hb >= $past(q.hb)) && (q.quest == $past(q.quest) + 4'h1);
  endproperty
  a_unsync_keeps_hb: assert property (p_unsync_keeps_hb) else $error("unsynced valid wrong");

  property p_expire_add;
    expire && !init_evt && d.en |=> q.err == $past(q.err) + 4'h2;
  endproperty
  a_expire_add: assert property (p_expire_add) else $error("expiry did not add two");

  property p_expire_keep;
    expire && d.en |=> (q.hb == 8'h00) && (q.quest == $past(q.quest))
      ##1 ($past(ev_valid) || (q.quest == $past(q.quest, 2)));
  endproperty
  a_expire_keep: assert property (p_expire_keep) else $error("expiry changed question");

  property p_wrong_sync;
    eval && bad_all && is_sync && d.en |=> (q.hb == 8'h00) && (q.quest == $past(q.quest));
  endproperty
  a_wrong_sync: assert property (p_wrong_sync) else $error("wrong synced answer mishandled");

  property p_pos_reset;
    (eval || expire) && d.en |=> q.pos == 2'h0 && !q.bad;
  endproperty
  a_pos_reset: assert property (p_pos_reset) else $error("position not returned to first");

  property p_early_sync;
    resp_wr && is_sync && (q.pos != POS_LAST) && !expire && d.en |=> q.hb >= $past(q.hb);
  endproperty
  a_early_sync: assert property (p_early_sync) else $error("early sync reset heartbeat");

  property p_disabled;
    !q.en |-> (q.hb == 8'h00) && (q.err == 4'h0) && (q.pos == 2'h0);
  endproperty
  a_disabled: assert property (p_disabled) else $error("counters not held when disabled");

  property p_init;
    init_evt && d.en |=> q.init_pulse && (q.err == 4'h0) && (q.hb == 8'h00)
      ##1 (!q.init_pulse || $past(init_evt));
  endproperty
  a_init: assert property (p_init) else $error("overflow did not move to init");

  property p_new_question;
    ev_valid && is_sync && d.en |=> (q.hb == 8'h00) && (q.quest != $past(q.quest));
  endproperty
  a_new_question: assert property (p_new_question) else $error("new question without restart");

  property p_table_zero;
    (q.quest == 4'h0) && (q.pos == 2'h0) |-> exp_byte == 8'hff;
  endproperty
  a_table_zero: assert property (p_table_zero) else $error("table row zero wrong");

  property p_resp_count;
    resp_wr && (q.pos != POS_LAST) && !expire && d.en |=> q.pos == $past(q.pos) + 2'h1;
  endproperty
  a_resp_count: assert property (p_resp_count) else $error("position did not advance");

  property p_no_early_eval;
    resp_wr && (q.pos != POS_LAST) && !expire && d.en |=>
      (q.err == $past(q.err)) && (q.quest == $past(q.quest));
  endproperty
  a_no_early_eval: assert property (p_no_early_eval) else $error("answer judged early");

  property p_wrong_plain;
    eval && bad_all && !is_sync && d.en |=> q.quest == $past(q.quest);
  endproperty
  a_wrong_plain: assert property (p_wrong_plain) else $error("question moved");

  property p_wrong_add;
    eval && bad_all && !init_evt && d.en |=> q.err == $past(q.err) + 4'h2;
  endproperty
  a_wrong_add: assert property (p_wrong_add) else $error("wrong answer did not add two");

  property p_byte_check;
    resp_wr && mismatch && !eval && !expire && d.en |=> q.bad;
  endproperty
  a_byte_check: assert property (p_byte_check) else $error("bad byte not noted");

  property p_quest_stable;
    !ev_valid |=> q.quest == $past(q.quest);
  endproperty
  a_quest_stable: assert property (p_quest_stable) else $error("question moved");

  property p_hb_count;
    q.en && q.tick && !expire && !eval && d.en && (q.hb != 8'hff) |=>
      q.hb == $past(q.hb) + 8'h01;
  endproperty
  a_hb_count: assert property (p_hb_count) else $error("heartbeat did not count");

  property p_hb_hold;
    !q.tick && !eval && d.en |=> q.hb == $past(q.hb);
  endproperty
  a_hb_hold: assert property (p_hb_hold) else $error("heartbeat moved off tick");

  property p_expire_event;
    expire |=> q.ev[EV_EXPIRE] && q.ev[EV_INVALID];
  endproperty
  a_expire_event: assert property (p_expire_event) else $error("expiry event missing");

  property p_valid_event;
    ev_valid |=> q.ev[EV_VALID] && q.outcome;
  endproperty
  a_valid_event: assert property (p_valid_event) else $error("valid outcome missing");

  property p_wrong_event;
    eval && bad_all |=> q.ev[EV_INVALID] && !q.outcome;
  endproperty
  a_wrong_event: assert property (p_wrong_event) else $error("invalid outcome missing");

  property p_wrong_hb_runs;
    eval && bad_all && !is_sync && !init_evt && d.en |=> q.hb >= $past(q.hb);
  endproperty
  a_wrong_hb_runs: assert property (p_wrong_hb_runs) else $error("heartbeat reset");

  property p_init_event;
    init_evt |=> q.ev[EV_INIT] && q.ev[EV_INVALID];
  endproperty
  a_init_event: assert property (p_init_event) else $error("init event missing");

  property p_table_last;
    (q.quest == 4'hf) && (q.pos == POS_LAST) |-> exp_byte == 8'hfe;
  endproperty
  a_table_last: assert property (p_table_last) else $error("table row fifteen wrong");

  c_valid_sync: cover property (ev_valid && is_sync);
  c_valid_unsync: cover property (ev_valid && !is_sync);
  c_expire: cover property (expire);
  c_init: cover property (init_evt);
  c_wrong_sync: cover property (eval && bad_all && is_sync);
endmodule

// file: qa_watchdog_pkg.sv
// Purpose: shared constants and types for the question/answer watchdog
// Assumes: 20 MHz reference clock, 32-bit APB register access
// Notes: register word offsets are byte addresses
package qa_watchdog_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CYCLE_LONG_US = 1000;
  localparam int CYCLE_SHORT_US = 100;
  localparam int CYCLE_LONG_CLKS = CYCLE_LONG_US * CLK_MHZ;
  localparam int CYCLE_SHORT_CLKS = CYCLE_SHORT_US * CLK_MHZ;
  localparam int DIV_W = 16;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HB_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_ERR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_ANSWER_PLAIN = 8'h10;
  localparam logic [7:0] ADDR_ANSWER_SYNC = 8'h14;
  localparam logic [7:0] ADDR_EVENT = 8'h18;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h1c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int ST_QUEST_LSB = 0;
  localparam int ST_POS_LSB = 4;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_OUTCOME_BIT = 12;
  localparam int EV_VALID = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_EXPIRE = 2;
  localparam int EV_INIT = 3;

  localparam logic [7:0] HB_PERIOD_RST = 8'h20;
  localparam logic [3:0] ERR_LIMIT_RST = 4'h8;
  localparam logic [4:0] ERR_INC = 5'h02;
  localparam logic [3:0] ERR_DEC = 4'h1;
  localparam logic [1:0] POS_LAST = 2'h3;

  typedef enum logic {PH_OFF, PH_RUN} phase_t;

  typedef struct packed {
    phase_t ph;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [7:0] hb;
    logic [3:0] quest;
    logic [1:0] pos;
    logic bad;
    logic [3:0] err;
    logic outcome;
    logic en;
    logic cyc_short;
    logic [7:0] hb_per;
    logic [3:0] limit;
    logic [3:0] ev;
    logic [3:0] mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic init_pulse;
  } wd_state_t;
endpackage

// file: testbench.sv
// Purpose: self-checking bench for the question/answer watchdog
// Assumes: cycle lengths shortened to 20 and 4 clocks
// Notes: random answers come from an lfsr with a fixed seed
module testbench
  import qa_watchdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, pen, pwr, prdy, perr, irq, mti, e, oc;
  logic [7:0] pa;
  logic [31:0] pwd, prd, rd, s, a;
  logic [3:0] q, err, lim;
  int errors, samples_checked, cyc, inits, x_inits, c0;
  logic [31:0] tbl [16] = '{32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
    32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3, 32'hd222dd2d, 32'h9d6d9262,
    32'hc434cb3b, 32'h8b7b8474, 32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};
  qa_watchdog #(.LONG_CYCLES(20), .SHORT_CYCLES(4)) dut (.ref_clk_in(clk), .rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .irq_out(irq),
    .move_to_init_out(mti));
  mcu_master mcu (.clk_in(clk), .pready_in(prdy), .pslverr_in(perr), .prdata_in(prd),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(pa), .pwdata_out(pwd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mti === 1'b1) inits++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rd_reg(input logic [7:0] ad);
    mcu.xfer(1'b0, ad, 32'h0, rd, e);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    mcu.xfer(1'b1, ad, d, rd, e);
  endtask
  // irq is registered, so let the write edge land first
  task irq_chk(input logic x);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask
  task st_chk(input logic [31:0] extra);
    rd_reg(ADDR_STATUS);
    chk(rd, {19'h0, oc, err, 4'h0, q} | extra);
  endtask
  // expected counter and question after one evaluation
  function automatic void judge(input logic ok);
    if (ok && err != 4'h0) err--;
    if (ok) q++;
    else if ({1'b0, err} + 5'd2 > {1'b0, lim}) begin
      err = 4'h0;
      x_inits++;
    end else err += 4'h2;
    oc = ok;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task wait_exp();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[EV_EXPIRE] !== 1'b1 && n < 200) begin
      rd_reg(ADDR_EVENT);
      n++;
    end
    chk({31'h0, rd[EV_EXPIRE]}, 32'h1);
    wr(ADDR_EVENT, 32'hf);
    judge(1'b0);
  endtask
  initial begin
    rst = 1'b1;
    q = 4'h0;
    err = 4'h0;
    lim = ERR_LIMIT_RST;
    oc = 1'b0;
    s = 32'h1523dfa6;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    st_chk(32'h0);
    rd_reg(ADDR_HB_PERIOD);
    chk(rd, {24'h0, HB_PERIOD_RST});
    rd_reg(8'h20);
    chk({rd[31:1], e}, 32'h1);
    $display("test reset done");
    wr(ADDR_HB_PERIOD, 32'hff);
    wr(ADDR_EVENT_MASK, 32'hf);
    wr(ADDR_CTRL, 32'h3);
    mcu.answer(tbl[0], 1'b1, 4);
    judge(1'b1);
    st_chk(32'h0);
    irq_chk(1'b1);
    wr(ADDR_EVENT_MASK, 32'h0);
    irq_chk(1'b0);
    wr(ADDR_EVENT_MASK, 32'hf);
    irq_chk(1'b1);
    wr(ADDR_EVENT, 32'hf);
    irq_chk(1'b0);
    $display("test irq done");
    a = tbl[q];
    mcu.answer({a[31:24], a[15:8], a[23:16], a[7:0]}, 1'b1, 4);
    judge(1'b0);
    st_chk(32'h0);
    $display("test swap done");
    repeat (16) begin
      s = lfsr(s);
      a = tbl[q];
      if (s[1]) a[8*s[3:2] +: 8] = a[8*s[3:2] +: 8] ^ {s[11:5], 1'b1};
      mcu.answer(a, s[0], 4);
      judge(!s[1]);
      st_chk(32'h0);
    end
    $display("test random done");
    // short heartbeat: about 36 clocks between expiries
    wr(ADDR_HB_PERIOD, 32'h8);
    wait_exp();
    a = tbl[q];
    mcu.answer({a[31:16], a[7:0], 8'h0}, 1'b1, 3);
    st_chk(32'h30);
    wait_exp();
    st_chk(32'h0);
    $display("test expiry done");
    wr(ADDR_CTRL, 32'h0);
    mcu.answer(tbl[q], 1'b0, 1);
    rd_reg(ADDR_STATUS);
    chk(rd & 32'hfff, {24'h0, 4'h0, q});
    err = 4'h0;
    $display("test disable done");
    wr(ADDR_HB_PERIOD, 32'hff);
    wr(ADDR_ERR_LIMIT, 32'h1);
    lim = 4'h1;
    wr(ADDR_CTRL, 32'h1);
    mcu.answer(~tbl[q], 1'b1, 4);
    c0 = cyc;
    judge(1'b0);
    st_chk(32'h0);
    // long cycle: a period of one needs two 20-clock ticks after the restart
    wr(ADDR_HB_PERIOD, 32'h1);
    wait_exp();
    chk({31'h0, (cyc - c0) >= 24}, 32'h1);
    st_chk(32'h0);
    chk(32'(inits), 32'(x_inits));
    $display("test overflow done");
    report_and_stop();
  end
endmodule
